/* File: design/bec_pkg.sv */
// constants, register map and types of the beam evaluation configuration block
package bec_pkg;
   // register bus
   localparam int          ADDR_W       = 12;
   localparam logic [3:0]  STRB_ALL     = 4'hf;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   // register indices; byte address is four times the index
   localparam logic [7:0]  IDX_GENERAL  = 8'h47;
   localparam logic [7:0]  IDX_EXTENDED = 8'h4a;
   localparam logic [7:0]  IDX_LOCK     = 8'h4e;
   localparam logic [7:0]  IDX_STATUS   = 8'h50;
   localparam logic [7:0]  IDX_BEAMS    = 8'h51;
   localparam logic [ADDR_W-1:0] ADR_GENERAL  = {2'h0, IDX_GENERAL, 2'h0};
   localparam logic [ADDR_W-1:0] ADR_EXTENDED = {2'h0, IDX_EXTENDED, 2'h0};
   localparam logic [ADDR_W-1:0] ADR_LOCK     = {2'h0, IDX_LOCK, 2'h0};
   localparam logic [ADDR_W-1:0] ADR_STATUS   = {2'h0, IDX_STATUS, 2'h0};
   localparam logic [ADDR_W-1:0] ADR_BEAMS    = {2'h0, IDX_BEAMS, 2'h0};
   // field positions
   localparam int          MODE_LSB     = 24;
   localparam int          DIR_LSB      = 16;
   localparam int          SMOOTH_LSB   = 8;
   localparam int          INV_LSB      = 0;
   localparam int          DEPTH_LSB    = 16;
   localparam int          HOLD_LSB     = 0;
   localparam int          ERR_BIT      = 0;
   localparam int          HOLDING_BIT  = 1;
   localparam int          SWITCH_BIT   = 2;
   localparam int          COUNT_LSB    = 16;
   // reset values and ranges
   localparam logic [31:0] GENERAL_RST  = 32'h0000_0101;
   localparam logic [31:0] EXTENDED_RST = 32'h0001_0000;
   localparam logic [7:0]  LOCK_RST     = 8'h00;
   localparam logic [7:0]  MODE_MAX     = 8'h02;
   localparam logic [7:0]  DIR_MAX      = 8'h01;
   localparam logic [7:0]  LOCK_MAX     = 8'h01;
   localparam logic [7:0]  MIN_ONE      = 8'h01;
   // timing
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          HOLD_UNIT_NS  = 1000000;
   localparam int          CYC_PER_MS    = HOLD_UNIT_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {MODE_PARALLEL, MODE_DIAGONAL, MODE_CROSSED} bec_mode_t;
   typedef enum logic {SER_IDLE, SER_SHIFT} bec_ser_t;
endpackage

/* File: design/bec_depth_filter.sv */
// per-beam consistency filter over consecutive measurement passes
`timescale 1ns/1ps
`default_nettype none
module bec_depth_filter #(
   parameter int W = 31
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   // pass in
   input  wire logic         in_v,
   input  wire logic [W-1:0] in_beams,
   input  wire logic [7:0]   depth,
   // pass out
   output logic              out_v_q,
   output logic [W-1:0]      out_beams_q
);
   import bec_pkg::*;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) out_v_q <= 1'b0;
      else out_v_q <= in_v;
   end

   for (genvar i = 0; i < W; i++) begin : g_beam
      logic [7:0] cnt_q;
      logic [8:0] next_cnt;
      assign next_cnt = {1'b0, cnt_q} + 9'h001;
      // a new state is accepted only after depth passes in a row
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            cnt_q          <= 8'h00;
            out_beams_q[i] <= 1'b0;
         end else if (in_v) begin
            if (in_beams[i] == out_beams_q[i]) begin
               cnt_q <= 8'h00;
            end else if (next_cnt >= {1'b0, depth}) begin
               out_beams_q[i] <= in_beams[i];
               cnt_q          <= 8'h00;
            end else begin
               cnt_q <= next_cnt[7:0];
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: design/bec_run_smooth.sv */
// suppresses runs of one beam state shorter than a minimum length
`timescale 1ns/1ps
`default_nettype none
module bec_run_smooth #(
   parameter int W = 31
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   // pass in
   input  wire logic         in_v,
   input  wire logic [W-1:0] in_beams,
   input  wire logic [W-1:0] span,
   input  wire logic [7:0]   min_run,
   input  wire logic         invert,
   // pass out
   output logic              out_v_q,
   output logic [W-1:0]      out_beams_q
);
   import bec_pkg::*;

   logic [W-1:0] tgt;
   logic [W-1:0] keep;
   logic [7:0]   left  [W];
   logic [7:0]   right [W];

   // targeted runs: interrupted beams, or free beams when inverted
   assign tgt = (invert ? ~in_beams : in_beams) & span;

   for (genvar i = 0; i < W; i++) begin : g_run
      logic [8:0] lsum;
      logic [8:0] rsum;
      if (i == 0) begin : g_l0
         assign lsum = 9'h001;
      end else begin : g_ln
         assign lsum = {1'b0, left[i-1]} + 9'h001;
      end
      if (i == W - 1) begin : g_r0
         assign rsum = 9'h001;
      end else begin : g_rn
         assign rsum = {1'b0, right[i+1]} + 9'h001;
      end
      // run lengths saturate at 255, the largest minimum
      assign left[i]  = !tgt[i] ? 8'h00 : (lsum[8] ? 8'hff : lsum[7:0]);
      assign right[i] = !tgt[i] ? 8'h00 : (rsum[8] ? 8'hff : rsum[7:0]);
      assign keep[i]  = tgt[i] && (({1'b0, left[i]} + {1'b0, right[i]}) > {1'b0, min_run});
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_v_q     <= 1'b0;
         out_beams_q <= '0;
      end else begin
         out_v_q <= in_v;
         if (in_v) out_beams_q <= (invert ? ~keep : keep) & span;
      end
   end
endmodule
`default_nettype wire

/* File: design/bec_top.sv */
// beam evaluation configuration and preprocessing with an AXI4-Lite register slave
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - scan pattern field: 0 parallel, 1 diagonal, 2 crossed; larger values invalid
// - direction 0 numbers from connection side, 1 from the opposite end
// - interrupted runs shorter than the smoothing value count as free
// - free runs shorter than the inverted smoothing value count as interrupted
// - interruption must last filter depth passes before switching follows
// - results accumulate and hold for the integration time in ms; 0 disables
// - lock 1 ignores the local buttons, 0 leaves them working
// - every logical beam state is shifted out serially, one bit each
// - all evaluation runs on logical beams whose count depends on mode
module bec_top
   import bec_pkg::*;
#(
   parameter int N_PHYS  = 16,
   parameter int N_BTN   = 4,
   parameter int MS_CYC  = CYC_PER_MS
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rstn,
   // axi4-lite write address, data and response
   input  wire logic [bec_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // axi4-lite read
   input  wire logic [bec_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // optics
   input  wire logic [N_PHYS-1:0]     beam_raw,
   input  wire logic                  beam_pass,
   // control panel
   input  wire logic [N_BTN-1:0]      btn_raw,
   output logic [N_BTN-1:0]           btn_eff,
   // evaluation results
   output logic [2*N_PHYS-2:0]        eval_beams,
   output logic                       eval_valid,
   output logic                       switch_out,
   output logic [15:0]                logical_count,
   // serial beam stream
   output logic                       ser_data,
   output logic                       ser_valid,
   output logic                       ser_last
);
   import bec_pkg::*;

   localparam int LOG_W = 2 * N_PHYS - 1;
   localparam int MS_W  = $clog2(MS_CYC + 1);

   // ---------------- register slave ----------------
   logic [31:0] general_q;
   logic [31:0] extended_q;
   logic [7:0]  lock_q;
   logic        err_q;
   logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic        wr_fire, rd_fire;
   logic [ADDR_W-1:0] waddr, raddr;
   logic        gen_ok, ext_ok, lock_ok, stat_wr, wr_err;
   logic        holding_q, switch_q;
   logic [LOG_W-1:0] eval_q;
   logic [15:0] count_q;

   assign waddr   = {s_axi_awaddr[ADDR_W-1:2], 2'h0};
   assign raddr   = {s_axi_araddr[ADDR_W-1:2], 2'h0};
   assign wr_fire = awready_q && s_axi_awvalid && s_axi_wvalid;
   assign rd_fire = arready_q && s_axi_arvalid;

   // records are accepted only whole and only with every field in range
   assign gen_ok = wr_fire && waddr == ADR_GENERAL && s_axi_wstrb == STRB_ALL
      && s_axi_wdata[MODE_LSB +: 8] <= MODE_MAX
      && s_axi_wdata[DIR_LSB +: 8] <= DIR_MAX
      && s_axi_wdata[SMOOTH_LSB +: 8] >= MIN_ONE
      && s_axi_wdata[INV_LSB +: 8] >= MIN_ONE;
   assign ext_ok = wr_fire && waddr == ADR_EXTENDED && s_axi_wstrb == STRB_ALL
      && s_axi_wdata[DEPTH_LSB +: 8] >= MIN_ONE;
   assign lock_ok = wr_fire && waddr == ADR_LOCK && s_axi_wstrb[0]
      && s_axi_wdata[7:0] <= LOCK_MAX;
   assign stat_wr = wr_fire && waddr == ADR_STATUS;
   assign wr_err  = wr_fire && !(gen_ok || ext_ok || lock_ok || stat_wr);

   // both channels are taken together in one cycle once both are offered
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         awready_q <= s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
         wready_q  <= s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_err ? RESP_SLVERR : RESP_OKAY;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         general_q  <= GENERAL_RST;
         extended_q <= EXTENDED_RST;
         lock_q     <= LOCK_RST;
      end else begin
         if (gen_ok) general_q <= s_axi_wdata;
         if (ext_ok) extended_q <= {8'h00, s_axi_wdata[DEPTH_LSB +: 8], 8'h00,
                                    s_axi_wdata[HOLD_LSB +: 8]};
         if (lock_ok) lock_q <= s_axi_wdata[7:0];
      end
   end

   // sticky rejection flag; a new rejection wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) err_q <= 1'b0;
      else if (wr_err) err_q <= 1'b1;
      else if (stat_wr && s_axi_wstrb[0] && s_axi_wdata[ERR_BIT]) err_q <= 1'b0;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= RESP_OKAY;
      end else begin
         arready_q <= s_axi_arvalid && !arready_q && !rvalid_q;
         if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= '0;
            case (raddr)
               ADR_GENERAL:  rdata_q <= general_q;
               ADR_EXTENDED: rdata_q <= extended_q;
               ADR_LOCK:     rdata_q <= {24'h0, lock_q};
               ADR_STATUS: begin
                  rdata_q[ERR_BIT]          <= err_q;
                  rdata_q[HOLDING_BIT]      <= holding_q;
                  rdata_q[SWITCH_BIT]       <= switch_q;
                  rdata_q[COUNT_LSB +: 16]  <= count_q;
               end
               ADR_BEAMS: begin
                  for (int i = 0; i < 32; i++) begin
                     if (i < LOG_W) rdata_q[i] <= eval_q[i];
                  end
               end
               default: rresp_q <= RESP_SLVERR;
            endcase
         end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // ---------------- configuration fields ----------------
   bec_mode_t  mode;
   logic       dir_inv;
   logic [7:0] smooth, inv_smooth, depth, hold_ms;

   assign mode       = bec_mode_t'(general_q[MODE_LSB +: 2]);
   assign dir_inv    = general_q[DIR_LSB];
   assign smooth     = general_q[SMOOTH_LSB +: 8];
   assign inv_smooth = general_q[INV_LSB +: 8];
   assign depth      = extended_q[DEPTH_LSB +: 8];
   assign hold_ms    = extended_q[HOLD_LSB +: 8];

   // ---------------- logical beams ----------------
   logic [LOG_W-1:0] map_c, ord_c, span_c;
   logic [15:0]      cnt_c;
   logic [LOG_W-1:0] s1_q, span_q;
   logic             s1_v_q;

   // diagonal beams lie between two neighbours; crossed ones need both interrupted
   always_comb begin
      map_c = '0;
      cnt_c = 16'(LOG_W);
      case (mode)
         MODE_PARALLEL: begin
            cnt_c = 16'(N_PHYS);
            for (int i = 0; i < N_PHYS; i++) map_c[i] = beam_raw[i];
         end
         MODE_DIAGONAL: begin
            for (int i = 0; i < N_PHYS; i++) map_c[2*i] = beam_raw[i];
            for (int i = 0; i < N_PHYS - 1; i++) map_c[2*i+1] = beam_raw[i] | beam_raw[i+1];
         end
         MODE_CROSSED: begin
            for (int i = 0; i < N_PHYS; i++) map_c[2*i] = beam_raw[i];
            for (int i = 0; i < N_PHYS - 1; i++) map_c[2*i+1] = beam_raw[i] & beam_raw[i+1];
         end
         default: map_c = '0;
      endcase
   end

   always_comb begin
      ord_c  = '0;
      span_c = '0;
      for (int i = 0; i < LOG_W; i++) begin
         if (i < int'(cnt_c)) begin
            span_c[i] = 1'b1;
            ord_c[i]  = dir_inv ? map_c[int'(cnt_c) - 1 - i] : map_c[i];
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_q    <= '0;
         span_q  <= '0;
         s1_v_q  <= 1'b0;
         count_q <= 16'h0000;
      end else begin
         s1_v_q <= beam_pass;
         if (beam_pass) begin
            s1_q    <= ord_c;
            span_q  <= span_c;
            count_q <= cnt_c;
         end
      end
   end

   // ---------------- filtering and smoothing ----------------
   logic             f_v, sm_v, ism_v;
   logic [LOG_W-1:0] f_beams, sm_beams, ism_beams;

   bec_depth_filter #(.W(LOG_W)) u_filter (
      .clk         (clk),
      .rstn        (rstn),
      .in_v        (s1_v_q),
      .in_beams    (s1_q),
      .depth       (depth),
      .out_v_q     (f_v),
      .out_beams_q (f_beams)
   );

   bec_run_smooth #(.W(LOG_W)) u_smooth (
      .clk         (clk),
      .rstn        (rstn),
      .in_v        (f_v),
      .in_beams    (f_beams),
      .span        (span_q),
      .min_run     (smooth),
      .invert      (1'b0),
      .out_v_q     (sm_v),
      .out_beams_q (sm_beams)
   );

   bec_run_smooth #(.W(LOG_W)) u_inv_smooth (
      .clk         (clk),
      .rstn        (rstn),
      .in_v        (sm_v),
      .in_beams    (sm_beams),
      .span        (span_q),
      .min_run     (inv_smooth),
      .invert      (1'b1),
      .out_v_q     (ism_v),
      .out_beams_q (ism_beams)
   );

   // ---------------- hold (integration) ----------------
   logic [MS_W-1:0]  ms_cnt_q;
   logic             ms_tick;
   logic [7:0]       hold_cnt_q;
   logic [LOG_W-1:0] acc_q;
   logic             publish;
   logic [LOG_W-1:0] pub_beams;

   assign ms_tick = ms_cnt_q == MS_W'(MS_CYC - 1);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) ms_cnt_q <= '0;
      else if (ms_tick) ms_cnt_q <= '0;
      else ms_cnt_q <= ms_cnt_q + 1'b1;
   end

   // with a hold time the window ends on a millisecond tick and publishes the union
   assign publish   = (hold_ms == 8'h00) ? ism_v : (ms_tick && hold_cnt_q + 8'h01 >= hold_ms);
   assign pub_beams = (hold_ms == 8'h00) ? ism_beams : (acc_q | (ism_v ? ism_beams : '0));

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hold_cnt_q <= 8'h00;
         acc_q      <= '0;
         holding_q  <= 1'b0;
      end else if (hold_ms == 8'h00) begin
         hold_cnt_q <= 8'h00;
         acc_q      <= '0;
         holding_q  <= 1'b0;
      end else begin
         holding_q <= 1'b1;
         if (publish) begin
            hold_cnt_q <= 8'h00;
            acc_q      <= '0;
         end else begin
            if (ms_tick) hold_cnt_q <= hold_cnt_q + 8'h01;
            if (ism_v) acc_q <= acc_q | ism_beams;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         eval_q      <= '0;
         switch_q    <= 1'b0;
         eval_valid  <= 1'b0;
      end else begin
         eval_valid <= publish;
         if (publish) begin
            eval_q   <= pub_beams;
            switch_q <= |pub_beams;
         end
      end
   end

   // ---------------- serial beam stream ----------------
   bec_ser_t         ser_st_q;
   logic [LOG_W-1:0] shift_q;
   logic [15:0]      left_q;

   // a new result restarts the stream; the consumer must keep up with one bit a cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ser_st_q  <= SER_IDLE;
         shift_q   <= '0;
         left_q    <= 16'h0000;
         ser_data  <= 1'b0;
         ser_valid <= 1'b0;
         ser_last  <= 1'b0;
      end else if (publish) begin
         ser_st_q  <= SER_SHIFT;
         shift_q   <= pub_beams;
         left_q    <= count_q;
         ser_valid <= 1'b0;
         ser_last  <= 1'b0;
      end else begin
         case (ser_st_q)
            SER_SHIFT: begin
               ser_data  <= shift_q[0];
               ser_valid <= 1'b1;
               ser_last  <= left_q == 16'h0001;
               shift_q   <= shift_q >> 1;
               left_q    <= left_q - 16'h0001;
               if (left_q == 16'h0001) ser_st_q <= SER_IDLE;
            end
            SER_IDLE: begin
               ser_valid <= 1'b0;
               ser_last  <= 1'b0;
            end
            default: ser_st_q <= SER_IDLE;
         endcase
      end
   end

   // ---------------- control panel ----------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) btn_eff <= '0;
      else btn_eff <= lock_q[0] ? '0 : btn_raw;
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign eval_beams    = eval_q;
   assign switch_out    = switch_q;
   assign logical_count = count_q;
endmodule
`default_nettype wire

/* File: verification/bec_top_chk.sv */
// concurrent checks on the ports of the beam evaluation block
`timescale 1ns/1ps
`default_nettype none
module bec_top_chk #(
   parameter int N_PHYS = 16,
   parameter int N_BTN  = 4
) (
   input wire logic              clk,
   input wire logic              rstn,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wready,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic              s_axi_arready,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [N_BTN-1:0]  btn_raw,
   input wire logic [N_BTN-1:0]  btn_eff,
   input wire logic [2*N_PHYS-2:0] eval_beams,
   input wire logic              eval_valid,
   input wire logic              switch_out,
   input wire logic [15:0]       logical_count,
   input wire logic              ser_valid,
   input wire logic              ser_last
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   rec_whole_a: assert property (s_axi_awready == s_axi_wready)
      else $error("aw and w split");
   wr_resp_a: assert property (s_axi_awready |=> s_axi_bvalid)
      else $error("bvalid late");
   rd_resp_a: assert property (s_axi_arready |=> s_axi_rvalid)
      else $error("rvalid late");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("rdata not held");
   btn_pass_a: assert property (|btn_eff |-> btn_eff == $past(btn_raw))
      else $error("btn_eff wrong");
   switch_or_a: assert property (!eval_valid |-> switch_out == (|eval_beams))
      else $error("switch_out wrong");
   beam_count_a: assert property (logical_count inside {16'h0, 16'(N_PHYS),
      16'(2*N_PHYS-1)})
      else $error("bad beam count");
   ser_last_a: assert property (ser_last |-> ser_valid)
      else $error("stray ser_last");
endmodule
bind bec_top bec_top_chk #(.N_PHYS(N_PHYS), .N_BTN(N_BTN)) chk (.clk, .rstn,
   .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .btn_raw, .btn_eff, .eval_beams,
   .eval_valid, .switch_out, .logical_count, .ser_valid, .ser_last);
`default_nettype wire

/* File: verification/bec_master_model.sv */
// AXI4-Lite master model
`timescale 1ns/1ps
`default_nettype none
module bec_master_model (
   input  wire logic        clk,
   output logic [11:0]      awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   output logic [11:0]      araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      logic aw = 1'b1, w = 1'b1;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (aw || w) begin
         @(posedge clk);
         if (awready) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (wready) begin
            w = 1'b0;
            wvalid <= 1'b0;
            wdata <= ~d;
         end
      end
      while (!bvalid) @(posedge clk);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge clk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: verification/beam_evaluation_config_tb.sv */
// bench for bec_top
`timescale 1ns/1ps
`default_nettype none
module beam_evaluation_config_tb;
   import bec_pkg::*;
   logic clk = 0, rstn = 0, beam_pass = 0;
   logic [15:0] beam_raw = '0;
   logic [3:0]  btn_raw = '0;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, eval32;
   logic [3:0]  wstrb, btn_eff;
   logic [1:0]  bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [30:0] eval_beams;
   logic eval_valid, switch_out;
   logic [15:0] logical_count;
   int n_mismatch = 0, samples_checked = 0;
   always #5 clk = ~clk;
   bec_top #(.MS_CYC(20)) uut (.clk, .rstn, .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .beam_raw, .beam_pass, .btn_raw, .btn_eff,
      .eval_beams, .eval_valid, .switch_out, .logical_count,
      .ser_data(), .ser_valid(), .ser_last());
   bec_master_model m (.clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready);
   task automatic print_verdict;
      $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic reg_w(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      m.wr(a, d, STRB_ALL, r);
      chk("bresp", 32'(er), 32'(r));
   endtask
   task automatic reg_r(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      m.rd(a, d, r);
      chk("rresp", 32'(er), 32'(r));
      chk("rdata", e, d);
   endtask
   task automatic wait_ev(input int n);
      int i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (eval_valid !== 1'b1 && i < n);
      chk("eval_valid", 32'h1, 32'(eval_valid));
      eval32 = 32'(eval_beams);
   endtask
   task automatic pass(input logic [15:0] v, input logic [31:0] e);
      @(posedge clk);
      beam_raw <= v;
      beam_pass <= 1'b1;
      @(posedge clk);
      beam_pass <= 1'b0;
      wait_ev(50);
      chk("eval_beams", e, eval32);
   endtask
   task automatic t_defaults_and_range;
      reg_r(ADR_GENERAL, GENERAL_RST, RESP_OKAY);
      reg_r(ADR_EXTENDED, EXTENDED_RST, RESP_OKAY);
      reg_r(ADR_LOCK, 32'h0, RESP_OKAY);
      reg_w(ADR_GENERAL, 32'h0300_0101, RESP_SLVERR);
      reg_w(ADR_GENERAL, 32'h0002_0101, RESP_SLVERR);
      reg_w(ADR_GENERAL, 32'h0000_0001, RESP_SLVERR);
      reg_w(ADR_EXTENDED, 32'h0000_0000, RESP_SLVERR);
      reg_w(ADR_LOCK, 32'h2, RESP_SLVERR);
      reg_r(ADR_GENERAL, GENERAL_RST, RESP_OKAY);
      reg_r(12'h004, 32'h0, RESP_SLVERR);
   endtask
   task automatic t_modes;
      logic [31:0] exp_b [3] = '{32'h10, 32'h380, 32'h100};
      for (int k = 0; k < 3; k++) begin
         reg_w(ADR_GENERAL, {8'(k), 24'h00_0101}, RESP_OKAY);
         pass(16'h0010, exp_b[k]);
         chk("logical_count", (k == 0) ? 32'd16 : 32'd31, 32'(logical_count));
      end
   endtask
   task automatic t_shape;
      reg_w(ADR_GENERAL, 32'h0001_0101, RESP_OKAY);
      pass(16'h0010, 32'h800);
      reg_w(ADR_GENERAL, 32'h0000_0301, RESP_OKAY);
      pass(16'h0030, 32'h0);
      pass(16'h0070, 32'h70);
      reg_w(ADR_GENERAL, 32'h0000_0102, RESP_OKAY);
      pass(16'h0028, 32'h38);
   endtask
   task automatic t_depth;
      reg_w(ADR_EXTENDED, 32'h0003_0000, RESP_OKAY);
      repeat (2) pass(16'h0, 32'h38);
      pass(16'h0, 32'h0);
      pass(16'h0010, 32'h0);
      pass(16'h0010, 32'h0);
      pass(16'h0010, 32'h10);
      chk("switch_out", 32'h1, 32'(switch_out));
      reg_w(ADR_EXTENDED, 32'h0001_0000, RESP_OKAY);
   endtask
   task automatic t_hold_lock;
      reg_w(ADR_EXTENDED, 32'h0001_0002, RESP_OKAY);
      wait_ev(200);
      beam_raw <= 16'h0001;
      beam_pass <= 1'b1;
      @(posedge clk);
      beam_raw <= 16'h8000;
      @(posedge clk);
      beam_pass <= 1'b0;
      wait_ev(200);
      chk("eval_beams", 32'h8001, eval32);
      btn_raw <= 4'ha;
      reg_w(ADR_LOCK, 32'h1, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("btn_eff", 32'h0, 32'(btn_eff));
      reg_w(ADR_LOCK, 32'h0, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("btn_eff", 32'ha, 32'(btn_eff));
   endtask
   initial begin
      #200000;
      n_mismatch++;
      print_verdict();
   end
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      t_defaults_and_range();
      t_modes();
      t_shape();
      t_depth();
      t_hold_lock();
      print_verdict();
   end
endmodule
`default_nettype wire
